// ===== core/wpu_top.sv
// watchpoint unit: comparators, vector catch, pc sampling and registers
// assumes core signals synchronous to i_clk and an AXI4-Lite master
`timescale 1ns/1ps
module wpu_top (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// core address paths and exception entry
	input wire wpu_pkg::wpu_fetch_s i_fetch,
	input wire wpu_pkg::wpu_data_s i_data,
	input wire wpu_pkg::wpu_exec_s i_exec,
	input wire wpu_pkg::wpu_exc_s i_exc,
	// core state
	input wire logic i_halted,
	input wire logic i_nid_ok,
	input wire logic i_local_rst,
	// halt requests
	output logic o_wp_halt,
	output logic o_vc_halt,
	// write address channel
	input wire logic i_awvalid,
	input wire logic [wpu_pkg::AW-1:0] i_awaddr,
	output logic o_awready,
	// write data channel
	input wire logic i_wvalid,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	output logic o_wready,
	// write response channel
	output logic o_bvalid,
	output logic [1:0] o_bresp,
	input wire logic i_bready,
	// read address channel
	input wire logic i_arvalid,
	input wire logic [wpu_pkg::AW-1:0] i_araddr,
	output logic o_arready,
	// read data channel
	output logic o_rvalid,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	input wire logic i_rready
);
	import wpu_pkg::*;

	typedef struct packed {
		logic [NUM_COMP-1:0][31:0] cref;
		logic [NUM_COMP-1:0][4:0] cmask;
		logic [NUM_COMP-1:0][3:0] cfunc;
		logic [NUM_COMP-1:0] matched;
		logic gen;
		logic hf_catch;
		logic rst_catch;
		logic dbg_en;
		logic flt_watch;
		logic flt_vc;
		logic [31:0] pc;
		logic pc_ok;
		logic vc_pend;
		logic wp_halt;
		logic vc_halt;
		logic awready;
		logic wready;
		logic aw_got;
		logic w_got;
		logic [AW-1:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} wpu_state_s;

	wpu_state_s s_q;
	wpu_state_s s_d;
	logic [NUM_COMP-1:0] hit;

	////////////////////////////////////////////////////////////////////////
	// comparator sets

	for (genvar g = 0; g < NUM_COMP; g++) begin : g_cmp
		wpu_comparator u_cmp (
			.i_ref(s_q.cref[g]),
			.i_mask(s_q.cmask[g]),
			.i_func(s_q.cfunc[g]),
			.i_fetch(i_fetch),
			.i_data(i_data),
			.o_match(hit[g])
		);
	end

	////////////////////////////////////////////////////////////////////////
	// helpers

	// byte-lane merge of a write into the current register word
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return res;
	endfunction

	// larger sizes settle at the maximum so software can probe it
	function automatic logic [4:0] clamp_mask(input logic [4:0] m);
		logic [4:0] res;
		res = m;
		if (m > MASK_MAX) begin
			res = MASK_MAX; // R08
		end
		return res;
	endfunction

	// {in comparator range, word within set, comparator index}
	function automatic logic [CIDX_W+2:0] comp_dec(input logic [AW-1:0] a);
		logic [AW-1:0] off;
		logic inr;
		off = a - OFF_COMP_BASE;
		inr = (a >= OFF_COMP_BASE) && (a < OFF_COMP_END);
		return {inr, off[3:2], off[CIDX_W+3:4]};
	endfunction

	function automatic logic [31:0] exc_word(input wpu_state_s s);
		logic [31:0] w;
		w = 32'h0;
		w[BIT_GEN] = s.gen;
		w[BIT_HF_CATCH] = s.hf_catch;
		w[BIT_RST_CATCH] = s.rst_catch;
		return w;
	endfunction

	function automatic logic [31:0] pc_word(input wpu_state_s s,
		input logic halted, input logic nid);
		logic [31:0] w;
		w = 32'h0;
		if (!PC_SAMPLE_IMPL) begin
			w = 32'h0; // R17
		end else if (halted || !nid || !s.pc_ok) begin
			w = ALL_ONES; // R16
		end else begin
			// bit 0 never carries state here
			w = {s.pc[31:1], 1'h0};
		end
		return w;
	endfunction

	// returns {answer, data} for a word-aligned read address
	function automatic logic [33:0] read_word(input wpu_state_s s,
		input logic [AW-1:0] a, input logic halted, input logic nid);
		logic [CIDX_W+2:0] dec;
		logic [CIDX_W-1:0] idx;
		logic [31:0] d;
		logic [1:0] r;
		dec = comp_dec(a);
		idx = dec[CIDX_W-1:0];
		d = 32'h0;
		r = RESP_OKAY;
		if (a == OFF_CTRL) begin
			d[CNT_LSB +: 4] = 4'(NUM_COMP); // R05
		end else if (a == OFF_PCSR) begin
			// no gating by the global enable: any value is allowed then
			d = pc_word(s, halted, nid); // R19
		end else if (dec[CIDX_W+2]) begin
			case (dec[CIDX_W+1:CIDX_W])
				REG_REF: d = s.cref[idx];
				REG_MASK: d[4:0] = s.cmask[idx];
				REG_FUNC: begin
					d[3:0] = s.cfunc[idx];
					d[BIT_MATCHED] = s.matched[idx];
				end
				default: r = RESP_SLVERR;
			endcase
		end else if (a == OFF_EXC_CTRL) begin
			d = exc_word(s);
		end else if (a == OFF_FAULT) begin
			d[BIT_FLT_WATCH] = s.flt_watch;
			d[BIT_FLT_VCATCH] = s.flt_vc;
		end else if (a == OFF_HALT_CTRL) begin
			d[BIT_DBG_EN] = s.dbg_en;
			d[BIT_HALTED] = halted;
		end else begin
			r = RESP_SLVERR;
		end
		return {r, d};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		logic [AW-1:0] wa;
		logic [AW-1:0] ra;
		logic [CIDX_W+2:0] wdec;
		logic [CIDX_W+2:0] rdec;
		logic [CIDX_W-1:0] wi;
		logic [31:0] w;
		logic [33:0] rd;
		logic wp_ev;
		logic hf_ev;
		wa = {s_q.awaddr[AW-1:2], 2'h0};
		ra = {i_araddr[AW-1:2], 2'h0};
		wdec = comp_dec(wa);
		rdec = comp_dec(ra);
		wi = wdec[CIDX_W-1:0];
		w = 32'h0;
		rd = 34'h0;
		wp_ev = 1'h0;
		hf_ev = 1'h0;
		s_d = s_q;

		// write channel capture, address and data in either order
		if (i_awvalid && s_q.awready) begin
			s_d.aw_got = 1'h1;
			s_d.awaddr = i_awaddr;
		end
		if (i_wvalid && s_q.wready) begin
			s_d.w_got = 1'h1;
			s_d.wdata = i_wdata;
			s_d.wstrb = i_wstrb;
		end
		if (s_q.bvalid && i_bready) begin
			s_d.bvalid = 1'h0;
		end

		// register write once both halves are held
		if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
			s_d.aw_got = 1'h0;
			s_d.w_got = 1'h0;
			s_d.bvalid = 1'h1;
			s_d.bresp = RESP_OKAY;
			if (wdec[CIDX_W+2]) begin
				case (wdec[CIDX_W+1:CIDX_W])
					REG_REF: begin
						s_d.cref[wi] = merge(s_q.cref[wi], s_q.wdata,
							s_q.wstrb);
					end
					REG_MASK: begin
						w = merge({27'h0, s_q.cmask[wi]}, s_q.wdata,
							s_q.wstrb);
						s_d.cmask[wi] = clamp_mask(w[4:0]); // R08
					end
					REG_FUNC: begin
						w = merge({28'h0, s_q.cfunc[wi]}, s_q.wdata,
							s_q.wstrb);
						s_d.cfunc[wi] = w[3:0]; // R06
					end
					default: s_d.bresp = RESP_SLVERR;
				endcase
			end else if (wa == OFF_EXC_CTRL) begin
				w = merge(exc_word(s_q), s_q.wdata, s_q.wstrb);
				s_d.gen = w[BIT_GEN]; // R22
				s_d.hf_catch = w[BIT_HF_CATCH];
				s_d.rst_catch = w[BIT_RST_CATCH];
			end else if (wa == OFF_FAULT) begin
				// write one to clear; new events below still win
				w = merge(32'h0, s_q.wdata, s_q.wstrb);
				if (w[BIT_FLT_WATCH]) begin
					s_d.flt_watch = 1'h0;
				end
				if (w[BIT_FLT_VCATCH]) begin
					s_d.flt_vc = 1'h0;
				end
			end else if (wa == OFF_HALT_CTRL) begin
				w = merge({31'h0, s_q.dbg_en}, s_q.wdata, s_q.wstrb);
				s_d.dbg_en = w[BIT_DBG_EN];
			end else if (wa == OFF_CTRL || wa == OFF_PCSR) begin
				// read-only words take the write and keep their value
				s_d.bresp = RESP_OKAY; // R15
			end else begin
				s_d.bresp = RESP_SLVERR;
			end
		end

		// read: data is sampled at the address handshake
		if (s_q.rvalid && i_rready) begin
			s_d.rvalid = 1'h0;
		end
		if (i_arvalid && s_q.arready) begin
			rd = read_word(s_q, ra, i_halted, i_nid_ok);
			s_d.rvalid = 1'h1;
			s_d.rresp = rd[33:32];
			s_d.rdata = rd[31:0];
			if (rdec[CIDX_W+2] && rdec[CIDX_W+1:CIDX_W] == REG_FUNC) begin
				s_d.matched[rdec[CIDX_W-1:0]] = 1'h0; // R24
			end
		end

		// pc sampling takes retired instructions only, never
		// fetched ones; condition-failed retirements count too
		if (i_exec.valid && !i_halted) begin
			s_d.pc = i_exec.addr; // R18
			s_d.pc_ok = 1'h1;
		end

		// watchpoints; flags are set after the clears so a match in
		// the cycle of the read-clear survives
		wp_ev = (|hit) && s_q.gen && !i_halted; // R25
		s_d.matched = s_d.matched | (hit & {NUM_COMP{s_q.gen}}); // R24
		// a held match raises a pulse every other cycle, never two in a row
		s_d.wp_halt = wp_ev && !s_q.wp_halt; // R04 R25
		if (wp_ev) begin
			// the core completes the access first, so it resumes
			// after the instruction that caused the event
			s_d.flt_watch = 1'h1; // R14 R03
		end

		// vector catch
		hf_ev = i_exc.entry && i_exc.hardfault && s_q.dbg_en &&
			s_q.hf_catch; // R21
		s_d.vc_halt = 1'h0;
		if (hf_ev) begin
			// raised at entry, ahead of the first handler instruction
			s_d.vc_halt = 1'h1; // R01 R02
			s_d.flt_vc = 1'h1; // R03
		end
		if (i_local_rst && s_q.dbg_en && s_q.rst_catch) begin
			s_d.vc_pend = 1'h1; // R21
		end
		if (s_q.vc_pend && !i_local_rst) begin
			// reset released: halt before the reset handler runs
			s_d.vc_pend = 1'h0;
			s_d.vc_halt = 1'h1; // R01 R02
			s_d.flt_vc = 1'h1; // R03
		end

		// local reset drops the global enable, pc sample and watch halt; catch enables stay
		if (i_local_rst) begin
			s_d.gen = 1'h0; // R26
			s_d.pc_ok = 1'h0;
			s_d.wp_halt = 1'h0;
		end

		// one write and one read in flight at most
		s_d.awready = !s_d.aw_got && !s_d.bvalid;
		s_d.wready = !s_d.w_got && !s_d.bvalid;
		s_d.arready = !s_d.rvalid;
	end

	////////////////////////////////////////////////////////////////////////
	// state register

	// power-on reset clears every action code and so every comparator
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			s_q <= '0; // R23
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	assign o_wp_halt = s_q.wp_halt;
	assign o_vc_halt = s_q.vc_halt;
	assign o_awready = s_q.awready;
	assign o_wready = s_q.wready;
	assign o_bvalid = s_q.bvalid;
	assign o_bresp = s_q.bresp;
	assign o_arready = s_q.arready;
	assign o_rvalid = s_q.rvalid;
	assign o_rdata = s_q.rdata;
	assign o_rresp = s_q.rresp;
endmodule

// ===== core/wpu_pkg.sv
// watchpoint unit constants, register map and carrier types
// assumes one 250 MHz clock and an AXI4-Lite master for the registers
// Function
// (R01) on a vector catch, halt at the first handler instruction
// (R02) vector catch halts before any instruction after the faulting one
// (R03) exception entry sets the matching debug fault status bits to 1
// (R04) every comparator watchpoint event halts the core into debug state
// (R05) a read-only field reports how many comparator sets exist
// (R06) 4-bit action code: off, fetch, read, write, read or write
// (R07) mask size clears that many low address bits before compare
// (R08) mask size clamps at an implementation maximum below 2GB range
// (R09) fetch matches only on the first halfword of an instruction
// (R10) debugger programs halfword aligned, already masked fetch references
// (R11) fetch action matches masked fetch address against the reference
// (R12) reference bit 0 ignored for halfwords, bits 1:0 for words
// (R13) data action matches masked data address in a permitted direction
// (R14) watchpoint halt is imprecise; resume lies after the culprit
// (R15) pc sample is read-only word access; writes are ignored
// (R16) pc sample reads all ones if halted, not permitted or unknown
// (R17) without pc sampling the register reads zero and ignores writes
// (R18) only executed instructions in the sequential stream are sampled
// (R19) with the global enable clear, pc sample reads may be anything
// (R20) debugger must use the halted status bit, not all ones
// (R21) vector catch needs halting debug, a catch enable and the exception
// (R22) bit 24 of exception control globally enables the watch unit
// (R23) power-on reset clears every action code, disabling comparators
// (R24) sticky matched flag per comparator, cleared by reading its action
// (R25) gated OR of matches drives a one-cycle halt request
// (R26) local reset clears the global enable, keeps both catch enables
package wpu_pkg;
	localparam int NUM_COMP = 4;
	localparam int CIDX_W = 2;
	localparam int AW = 12;
	localparam logic [4:0] MASK_MAX = 5'h10;
	localparam bit PC_SAMPLE_IMPL = 1'h1;
	localparam logic [31:0] ALL_ONES = 32'hFFFFFFFF;
	// byte offsets
	localparam logic [AW-1:0] OFF_CTRL = 12'h000;
	localparam logic [AW-1:0] OFF_PCSR = 12'h01C;
	localparam logic [AW-1:0] OFF_COMP_BASE = 12'h020;
	localparam logic [AW-1:0] OFF_COMP_END = 12'h060;
	localparam logic [AW-1:0] OFF_EXC_CTRL = 12'h100;
	localparam logic [AW-1:0] OFF_FAULT = 12'h104;
	localparam logic [AW-1:0] OFF_HALT_CTRL = 12'h108;
	// word within one comparator set
	localparam logic [1:0] REG_REF = 2'h0;
	localparam logic [1:0] REG_MASK = 2'h1;
	localparam logic [1:0] REG_FUNC = 2'h2;
	// field positions
	localparam int CNT_LSB = 28;
	localparam int BIT_MATCHED = 24;
	localparam int BIT_GEN = 24;
	localparam int BIT_HF_CATCH = 10;
	localparam int BIT_RST_CATCH = 0;
	localparam int BIT_FLT_WATCH = 2;
	localparam int BIT_FLT_VCATCH = 3;
	localparam int BIT_DBG_EN = 0;
	localparam int BIT_HALTED = 17;
	// action codes
	localparam logic [3:0] FN_OFF = 4'h0;
	localparam logic [3:0] FN_IADDR = 4'h4;
	localparam logic [3:0] FN_READ = 4'h5;
	localparam logic [3:0] FN_WRITE = 4'h6;
	localparam logic [3:0] FN_RDWR = 4'h7;
	// data access sizes
	localparam logic [1:0] SZ_BYTE = 2'h0;
	localparam logic [1:0] SZ_HALF = 2'h1;
	localparam logic [1:0] SZ_WORD = 2'h2;
	// bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic valid;
		logic [31:0] addr;
		logic first_half;
	} wpu_fetch_s;

	typedef struct packed {
		logic valid;
		logic [31:0] addr;
		logic [1:0] size;
		logic write;
	} wpu_data_s;

	typedef struct packed {
		logic valid;
		logic [31:0] addr;
	} wpu_exec_s;

	typedef struct packed {
		logic entry;
		logic hardfault;
	} wpu_exc_s;
endpackage

// ===== core/wpu_comparator.sv
// one address comparator set: masked fetch or data address match
// assumes its settings come from registers and addresses are one-cycle
`timescale 1ns/1ps
module wpu_comparator (
	// settings
	input wire logic [31:0] i_ref,
	input wire logic [4:0] i_mask,
	input wire logic [3:0] i_func,
	// address paths
	input wire wpu_pkg::wpu_fetch_s i_fetch,
	input wire wpu_pkg::wpu_data_s i_data,
	// result
	output logic o_match
);
	import wpu_pkg::*;

	logic [31:0] keep;
	logic [31:0] dref;
	logic dir_ok;

	always_comb begin
		keep = ALL_ONES << i_mask; // R07
		dref = i_ref;
		if (i_data.size == SZ_HALF) begin
			dref[0] = 1'h0; // R12
		end else if (i_data.size == SZ_WORD) begin
			dref[1:0] = 2'h0; // R12
		end
		case (i_func) // R06
			FN_READ: dir_ok = !i_data.write;
			FN_WRITE: dir_ok = i_data.write;
			FN_RDWR: dir_ok = 1'h1;
			default: dir_ok = 1'h0;
		endcase
		// second halfword fetches never match, so a 32-bit
		// instruction is caught on its first halfword only
		if (i_func == FN_IADDR) begin
			o_match = i_fetch.valid && i_fetch.first_half &&
				((i_fetch.addr & keep) == i_ref); // R09 R11
		end else begin
			o_match = dir_ok && i_data.valid &&
				((i_data.addr & keep) == dref); // R13
		end
	end
endmodule

// ===== verif/wpu_top_asserts.sv
// port checker for the watchpoint unit
// assumes one clock domain and a bind onto wpu_top
`timescale 1ns/1ps
module wpu_top_asserts import wpu_pkg::*; (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// core side
	input wire wpu_pkg::wpu_fetch_s i_fetch,
	input wire wpu_pkg::wpu_data_s i_data,
	input wire wpu_pkg::wpu_exc_s i_exc,
	input wire logic i_halted,
	input wire logic i_nid_ok,
	input wire logic i_local_rst,
	// halt requests
	input wire logic o_wp_halt,
	input wire logic o_vc_halt,
	// read channel
	input wire logic i_arvalid,
	input wire logic [wpu_pkg::AW-1:0] i_araddr,
	input wire logic o_arready,
	input wire logic [31:0] o_rdata
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rstn);
	////////////////////////////////////////////////////////////////////////
	// read taken here; the data shows in the next cycle
	sequence ar_take(logic [AW-1:0] a);
		i_arvalid && o_arready && i_araddr == a;
	endsequence

	wp_one_shot_a: assert property (o_wp_halt |=> !o_wp_halt)
		else $error("watch halt longer than one cycle");
	vc_one_shot_a: assert property (o_vc_halt |=> !o_vc_halt)
		else $error("catch halt longer than one cycle");
	wp_cause_a: assert property (o_wp_halt |->
		($past(i_fetch.valid) || $past(i_data.valid)) && !$past(i_halted))
		else $error("watch halt without access or while halted");
	vc_cause_a: assert property (o_vc_halt |->
		($past(i_exc.entry) && $past(i_exc.hardfault)) ||
		($past(i_local_rst, 2) && !$past(i_local_rst)))
		else $error("catch halt without exception or reset end");
	pcsr_ones_a: assert property (ar_take(OFF_PCSR) ##0
		(i_halted || !i_nid_ok) |=> o_rdata == ALL_ONES)
		else $error("pc sample not all ones");
	pcsr_even_a: assert property (ar_take(OFF_PCSR) |=>
		o_rdata[0] == 1'b0 || o_rdata == ALL_ONES)
		else $error("pc sample has bit 0 set");
	comp_count_a: assert property (ar_take(OFF_CTRL) |=>
		o_rdata[31:28] == 4'(NUM_COMP))
		else $error("comparator count wrong");
	mask_max_a: assert property (ar_take(12'h024) |=>
		o_rdata[4:0] <= MASK_MAX)
		else $error("mask size above maximum");
endmodule

bind wpu_top wpu_top_asserts u_chk (.i_clk, .i_rstn, .i_fetch, .i_data,
	.i_exc, .i_halted, .i_nid_ok, .i_local_rst, .o_wp_halt, .o_vc_halt,
	.i_arvalid, .i_araddr, .o_arready, .o_rdata);

// ===== verif/wpu_core_model.sv
// core model: sequential fetch and retire stream that stops on halt
// assumes the bench pulses i_resume to leave debug state
`timescale 1ns/1ps
module wpu_core_model (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// control
	input wire logic i_go,
	input wire logic i_resume,
	input wire logic i_wp_halt,
	input wire logic i_vc_halt,
	// core paths
	output wpu_pkg::wpu_fetch_s o_fetch,
	output wpu_pkg::wpu_exec_s o_exec,
	output logic o_halted,
	output logic [31:0] o_pc
);
	import wpu_pkg::*;
	logic run;
	assign run = i_go && !o_halted;
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_pc <= 32'h00001000;
			o_halted <= 1'b0;
			o_fetch <= '0;
			o_exec <= '0;
		end else begin
			// halt lands after later fetches: imprecise by nature
			if (i_wp_halt || i_vc_halt) o_halted <= 1'b1;
			else if (i_resume) o_halted <= 1'b0;
			o_fetch.valid <= run;
			// idle address toggles so stale values never match
			o_fetch.addr <= run ? o_pc : ~o_fetch.addr;
			o_fetch.first_half <= 1'b1;
			o_exec.valid <= o_fetch.valid && run;
			o_exec.addr <= o_fetch.addr;
			if (run) o_pc <= o_pc + 32'h2;
		end
	end
endmodule

// ===== verif/wpu_top_bench.sv
// self-checking bench for the watchpoint unit
// assumes the core model on the fetch side; bench is the bus master
`timescale 1ns/1ps
`define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin \
fail_count++; $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module wpu_top_bench;
	import wpu_pkg::*;
	localparam logic [33:0] FM = {34{1'b1}};
	logic clk = 1'b0, rstn = 1'b0, nid_ok = 1'b1, lrst = 1'b0;
	logic go = 1'b0, resume = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
	logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [AW-1:0] awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0, rdata, pc, r;
	wpu_data_s dacc = '0;
	wpu_exc_s exc = '0;
	wpu_fetch_s fetch;
	wpu_exec_s exec;
	logic halted, wp, vc, awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, b_v;
	logic [33:0] rq_e[$], rq_m[$], e_v, m_v;
	int fail_count = 0, n_compared = 0, wp_n = 0, vc_n = 0, m;

	always #2 clk = ~clk;

	wpu_top DUT (.i_clk(clk), .i_rstn(rstn), .i_fetch(fetch), .i_data(dacc),
		.i_exec(exec), .i_exc(exc), .i_halted(halted), .i_nid_ok(nid_ok),
		.i_local_rst(lrst), .o_wp_halt(wp), .o_vc_halt(vc),
		.i_awvalid(awvalid), .i_awaddr(awaddr), .o_awready(awready),
		.i_wvalid(wvalid), .i_wdata(wdata), .i_wstrb(4'hF),
		.o_wready(wready), .o_bvalid(bvalid), .o_bresp(bresp),
		.i_bready(bready), .i_arvalid(arvalid), .i_araddr(araddr),
		.o_arready(arready), .o_rvalid(rvalid), .o_rdata(rdata),
		.o_rresp(rresp), .i_rready(rready));
	wpu_core_model u_core (.i_clk(clk), .i_rstn(rstn), .i_go(go),
		.i_resume(resume), .i_wp_halt(wp), .i_vc_halt(vc), .o_fetch(fetch),
		.o_exec(exec), .o_halted(halted), .o_pc(pc));

	////////////////////////////////////////////////////////////////////////
	// watcher: oldest note against each answer, halt pulses counted
	always @(posedge clk) begin
		if (wp) wp_n++;
		if (vc) vc_n++;
		if (rvalid && rready) begin
			e_v = rq_e.pop_front();
			m_v = rq_m.pop_front();
			`CHK("read", e_v, {rresp, rdata} & m_v)
		end
		if (bvalid && bready) begin
			b_v = RESP_OKAY;
			`CHK("write resp", b_v, bresp)
		end
	end

	task automatic end_sim();
		$display("compared %0d failed %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic tmo(input int n);
		if (n >= 64) begin
			fail_count++;
			end_sim();
		end
	endtask

	task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= d;
		bready <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid && n < 64);
		bready <= 1'b0;
		tmo(n);
	endtask

	task automatic rd(input logic [AW-1:0] a, input logic [33:0] e,
		input logic [33:0] mk);
		int n;
		rq_e.push_back(e & mk);
		rq_m.push_back(mk);
		@(posedge clk);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
			if (arready) arvalid <= 1'b0;
		end while (!rvalid && n < 64);
		rready <= 1'b0;
		tmo(n);
	endtask

	// one cycle of core events, then count halts and let the core go
	task automatic stim(input wpu_data_s d, input wpu_exc_s x,
		input logic l, input int ew, input int ev);
		int bw, bv;
		bw = wp_n;
		bv = vc_n;
		@(posedge clk);
		dacc <= d;
		exc <= x;
		lrst <= l;
		@(posedge clk);
		dacc <= '{1'b0, ~d.addr, d.size, d.write};
		exc <= '0;
		lrst <= 1'b0;
		repeat (3) @(posedge clk);
		`CHK("watch halts", ew, wp_n - bw)
		`CHK("catch halts", ev, vc_n - bv)
		resume <= 1'b1;
		@(posedge clk);
		resume <= 1'b0;
	endtask

	initial begin
		void'($urandom(40724));
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		rd(OFF_CTRL, {RESP_OKAY, 4'(NUM_COMP), 28'h0}, FM);
		for (int i = 0; i < 4; i++) begin
			rd(OFF_COMP_BASE + 12'(16 * i + 8), '0, FM);
		end
		rd(12'h02C, {RESP_SLVERR, 32'h0}, FM);
		wr(12'h024, 32'h1F);
		rd(12'h024, {RESP_OKAY, 27'h0, MASK_MAX}, FM);
		wr(OFF_EXC_CTRL, 32'h1 << BIT_GEN);
		for (int f = 0; f < 16; f++) begin
			r = $urandom & 32'hFFFFFFFC;
			wr(12'h030, r);
			wr(12'h038, 32'(f));
			for (int w = 0; w < 2; w++) begin
				m = (f == 7) || (f == 5 && w == 0) || (f == 6 && w == 1);
				stim('{1'b1, r ^ 32'h100, SZ_BYTE, w[0]}, '0, 0, 0, 0);
				stim('{1'b1, r, SZ_WORD, w[0]}, '0, 0, m, 0);
				rd(12'h038, {9'h0, m[0], 20'h0, f[3:0]}, FM);
				rd(12'h038, {30'h0, f[3:0]}, FM);
			end
		end
		wr(12'h040, 32'h20000100);
		wr(12'h044, 32'h8);
		wr(12'h048, {28'h0, FN_RDWR});
		stim('{1'b1, 32'h200001FC, SZ_WORD, 1'b0}, '0, 0, 1, 0);
		stim('{1'b1, 32'h20000200, SZ_WORD, 1'b0}, '0, 0, 0, 0);
		wr(12'h044, 32'h0);
		wr(12'h040, 32'h20000103);
		stim('{1'b1, 32'h20000100, SZ_WORD, 1'b1}, '0, 0, 1, 0);
		stim('{1'b1, 32'h20000102, SZ_HALF, 1'b1}, '0, 0, 1, 0);
		stim('{1'b1, 32'h20000102, SZ_BYTE, 1'b1}, '0, 0, 0, 0);
		stim('0, 2'b11, 0, 0, 0);
		wr(OFF_HALT_CTRL, 32'h1);
		wr(OFF_EXC_CTRL, 32'h01000400);
		stim('0, 2'b10, 0, 0, 0);
		stim('0, 2'b11, 0, 0, 1);
		rd(OFF_FAULT, {RESP_OKAY, 32'h8}, {2'h3, 32'h8});
		go <= 1'b1;
		repeat (10) @(posedge clk);
		// the write must leave the sample visible to the read after it
		wr(OFF_PCSR, 32'h0);
		rd(OFF_PCSR, {RESP_OKAY, 32'h1000}, {2'h3, 32'hFFFFF001});
		nid_ok <= 1'b0;
		rd(OFF_PCSR, {RESP_OKAY, ALL_ONES}, FM);
		nid_ok <= 1'b1;
		r = pc + 32'h40;
		wr(12'h050, r);
		wr(12'h058, {28'h0, FN_IADDR});
		m = wp_n;
		for (int n = 0; n < 64 && !halted; n++) begin
			@(posedge clk);
		end
		`CHK("fetch halt", 1, wp_n - m)
		rd(OFF_PCSR, {RESP_OKAY, ALL_ONES}, FM);
		// halt is judged from the status bit, never from all ones
		rd(OFF_HALT_CTRL, {RESP_OKAY, 32'h00020001}, FM);
		go <= 1'b0;
		stim('0, '0, 0, 0, 0);
		wr(OFF_EXC_CTRL, 32'h01000401);
		stim('0, '0, 1, 0, 1);
		rd(OFF_EXC_CTRL, {RESP_OKAY, 32'h401}, FM);
		stim('{1'b1, 32'h20000100, SZ_WORD, 1'b1}, '0, 0, 0, 0);
		end_sim();
	end
endmodule
